// ===== shared/sap_pkg.sv
// Constants and types for the static RAM host controller
`default_nettype none
package sap_pkg;
   localparam int unsigned ADDR_W = 13; // 8192 words
   localparam int unsigned DATA_W = 8; // Byte wide
   localparam int unsigned CLK_PERIOD_NS = 5; // 200 MHz
   localparam int unsigned CNT_W = 6; // Width of the host timing and check counters
   // Printed times in ns, faster grade
   localparam int unsigned WRITE_PULSE_NS = 70;
   localparam int unsigned SELECT_TO_WRITE_END_MIN_NS = 85;
   localparam int unsigned ADDRESS_TO_WRITE_END_MIN_NS = 85;
   localparam int unsigned DATA_OVERLAP_MIN_NS = 50;
   localparam int unsigned RECOVERY_AFTER_LOW_SELECT_OR_STROBE_NS = 55;
   localparam int unsigned RECOVERY_AFTER_HIGH_SELECT_NS = 15;
   localparam int unsigned CYCLE_TIME_NS = 120;
   localparam int unsigned ACCESS_TIME_NS = 120;
   localparam int unsigned RELEASE_TO_HIGHZ_NS = 40;
   localparam int unsigned SYNC_STAGES = 3; // Pin input pipeline depth
   // Least times round up, never below one cycle
   function automatic int unsigned to_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c == 0) ? 1 : c;
   endfunction
   function automatic int unsigned max2(input int unsigned a, input int unsigned b);
      return (a > b) ? a : b;
   endfunction
   localparam logic [CNT_W-1:0] WP_CYC = CNT_W'(to_cyc(WRITE_PULSE_NS));
   localparam logic [CNT_W-1:0] CW_CYC = CNT_W'(to_cyc(SELECT_TO_WRITE_END_MIN_NS));
   localparam logic [CNT_W-1:0] AW_CYC = CNT_W'(to_cyc(ADDRESS_TO_WRITE_END_MIN_NS));
   localparam logic [CNT_W-1:0] DW_CYC = CNT_W'(to_cyc(DATA_OVERLAP_MIN_NS));
   localparam logic [CNT_W-1:0] WR1_CYC = CNT_W'(to_cyc(RECOVERY_AFTER_LOW_SELECT_OR_STROBE_NS));
   localparam logic [CNT_W-1:0] WR2_CYC = CNT_W'(to_cyc(RECOVERY_AFTER_HIGH_SELECT_NS));
   localparam logic [CNT_W-1:0] RC_CYC = CNT_W'(to_cyc(CYCLE_TIME_NS));
   localparam logic [CNT_W-1:0] HZ_CYC = CNT_W'(to_cyc(RELEASE_TO_HIGHZ_NS));
   // Strobe low time: pulse width, data window (data one cycle late), select lead of one cycle
   localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(max2(max2(to_cyc(WRITE_PULSE_NS),
      to_cyc(DATA_OVERLAP_MIN_NS) + 1), to_cyc(SELECT_TO_WRITE_END_MIN_NS) - 1));
   // Read wait: access time plus the input pipeline
   localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(to_cyc(ACCESS_TIME_NS) + SYNC_STAGES);
   typedef enum logic [2:0] {ST_IDLE, ST_WSET, ST_WPULSE, ST_WREC, ST_RACC, ST_TURN} sap_state_t;
endpackage
`default_nettype wire

// ===== shared/sap_sync_if.sv
// Carrier between the controller and its data pin synchroniser
`default_nettype none
interface sap_sync_if;
   import sap_pkg::*;
   logic [DATA_W-1:0] raw; // Data pins as they arrive
   logic [DATA_W-1:0] value; // Last stage of the pipeline
   logic agree; // Second and third stage match
   modport ctl (output raw, input value, input agree);
   modport syn (input raw, output value, output agree);
endinterface
`default_nettype wire

// ===== core/sap_sync.sv
// Three stage synchroniser for the shared data pins
`default_nettype none
module sap_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   sap_sync_if.syn sif
);
   import sap_pkg::*;
   logic [DATA_W-1:0] s1_r; // First stage, read only by s2
   logic [DATA_W-1:0] s2_r; // Second stage
   logic [DATA_W-1:0] s3_r; // Third stage
   // Plain shift; the pins are not related to clk_i
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= sif.raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // A value counts once the last two stages agree
   assign sif.value = s3_r;
   assign sif.agree = (s2_r == s3_r);
endmodule // sap_sync
`default_nettype wire

// ===== core/sap_host.sv
// Host controller driving an asynchronous 8K x 8 static RAM
`default_nettype none
module sap_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i, // Access request, taken when ready_o
   input wire logic we_i, // 1 write, 0 read
   input wire logic [sap_pkg::ADDR_W-1:0] addr_i, // Word address
   input wire logic [sap_pkg::DATA_W-1:0] wdata_i, // Write byte
   output logic ready_o, // Idle, next request may be taken
   output logic rvalid_o, // One cycle pulse with read byte
   output logic [sap_pkg::DATA_W-1:0] rdata_o, // Read byte
   output logic [sap_pkg::ADDR_W-1:0] ram_addr_o, // Address pins
   output logic select_low_active_n_o, // Low active select pin
   output logic select_high_active_o, // High active select pin
   output logic write_strobe_n_o, // Write strobe pin
   output logic output_gate_n_o, // Output gate pin
   input wire logic [sap_pkg::DATA_W-1:0] data_i, // Data pins in
   output logic [sap_pkg::DATA_W-1:0] data_o, // Data pins out
   output logic data_oe_o // High while we drive the data pins
);
   import sap_pkg::*;
   sap_state_t st_r, st_nxt; // Sequencer state
   logic [CNT_W-1:0] cnt_r, cnt_nxt; // Phase timer
   logic [ADDR_W-1:0] addr_r, addr_nxt; // Address pins
   logic [DATA_W-1:0] wdat_r, wdat_nxt; // Write byte
   logic [DATA_W-1:0] rdat_r, rdat_nxt; // Captured read byte
   logic sel_nxt; // Both selects active
   logic wr_nxt; // Strobe asserted
   logic gate_nxt; // Output gate asserted
   logic doe_nxt; // Data drivers on
   logic sel_n_r, sel_hi_r, strobe_n_r, gate_n_r, doe_r, ready_r, rvalid_r;
   sap_sync_if sif ();
   // Data pins pass three flops before use
   sap_sync u_sap_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sif(sif)
   );
   assign sif.raw = data_i;
   // Decodes for the sequencer
   wire cnt_zero = (cnt_r == '0);
   wire [CNT_W-1:0] cnt_dn = cnt_zero ? cnt_r : cnt_r - CNT_W'(1);
   wire take = req_i & ready_r & (st_r == ST_IDLE);
   wire sel_now = ~sel_n_r & sel_hi_r;
   wire gate_now = ~gate_n_r;
   wire wr_now = ~strobe_n_r;
   // Sequencer; pins hold unless a phase changes them
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_dn;
      addr_nxt = addr_r;
      wdat_nxt = wdat_r;
      rdat_nxt = rdat_r;
      sel_nxt = sel_now;
      wr_nxt = wr_now;
      gate_nxt = gate_now;
      doe_nxt = doe_r;
      case (st_r)
         ST_IDLE: begin
            if (take) begin
               // Address and both selects go out together, strobe still high
               addr_nxt = addr_i;
               sel_nxt = 1'b1;
               if (we_i) begin
                  wdat_nxt = wdata_i;
                  st_nxt = ST_WSET;
               end else begin
                  gate_nxt = 1'b1;
                  cnt_nxt = RD_CYC;
                  st_nxt = ST_RACC;
               end
            end
         end
         ST_WSET: begin
            // Strobe falls last, so it starts the write; gate stays high
            wr_nxt = 1'b1;
            cnt_nxt = PULSE_CYC - CNT_W'(1);
            st_nxt = ST_WPULSE;
         end
         ST_WPULSE: begin
            // Drivers come on one cycle after the strobe fell
            doe_nxt = 1'b1;
            if (cnt_zero) begin
               // Strobe rise ends the write; drivers off on the same edge
               wr_nxt = 1'b0;
               doe_nxt = 1'b0;
               cnt_nxt = WR1_CYC;
               st_nxt = ST_WREC;
            end
         end
         ST_WREC: begin
            // Selects drop after the strobe; address holds for the longer recovery
            sel_nxt = 1'b0;
            if (cnt_zero) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_RACC: begin
            // Capture only a settled byte after the full access time
            if (cnt_zero && sif.agree) begin
               rdat_nxt = sif.value;
               sel_nxt = 1'b0;
               gate_nxt = 1'b0;
               cnt_nxt = HZ_CYC;
               st_nxt = ST_TURN;
            end
         end
         ST_TURN: begin
            // RAM may still drive until its release time runs out
            if (cnt_zero) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
            sel_nxt = 1'b0;
            wr_nxt = 1'b0;
            gate_nxt = 1'b0;
            doe_nxt = 1'b0;
         end
      endcase
   end
   // State, timer and data registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= ST_IDLE;
         cnt_r <= '0;
         addr_r <= '0;
         wdat_r <= '0;
         rdat_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         addr_r <= addr_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
      end
   end
   // Pin and handshake flops; reset leaves the RAM deselected
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_n_r <= 1'b1;
         sel_hi_r <= 1'b0;
         strobe_n_r <= 1'b1;
         gate_n_r <= 1'b1;
         doe_r <= 1'b0;
         ready_r <= 1'b0;
         rvalid_r <= 1'b0;
      end else begin
         sel_n_r <= ~sel_nxt;
         sel_hi_r <= sel_nxt;
         strobe_n_r <= ~wr_nxt;
         gate_n_r <= ~gate_nxt;
         doe_r <= doe_nxt;
         ready_r <= (st_nxt == ST_IDLE);
         rvalid_r <= (st_r == ST_RACC) && (st_nxt == ST_TURN);
      end
   end
   assign ready_o = ready_r;
   assign rvalid_o = rvalid_r;
   assign rdata_o = rdat_r;
   assign ram_addr_o = addr_r;
   assign select_low_active_n_o = sel_n_r;
   assign select_high_active_o = sel_hi_r;
   assign write_strobe_n_o = strobe_n_r;
   assign output_gate_n_o = gate_n_r;
   assign data_o = wdat_r;
   assign data_oe_o = doe_r;
   // Helper counters for the checks below, saturating
   logic [CNT_W-1:0] low_cnt_r, sel_cnt_r, doe_cnt_r, end_cnt_r, gap_cnt_r;
   wire [CNT_W-1:0] sat_max = '1;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_cnt_r <= '0;
         sel_cnt_r <= '0;
         doe_cnt_r <= '0;
         end_cnt_r <= sat_max;
         gap_cnt_r <= sat_max;
      end else begin
         low_cnt_r <= strobe_n_r ? '0 : (low_cnt_r == sat_max ? low_cnt_r : low_cnt_r + CNT_W'(1));
         sel_cnt_r <= sel_n_r ? '0 : (sel_cnt_r == sat_max ? sel_cnt_r : sel_cnt_r + CNT_W'(1));
         doe_cnt_r <= !doe_r ? '0 : (doe_cnt_r == sat_max ? doe_cnt_r : doe_cnt_r + CNT_W'(1));
         end_cnt_r <= (strobe_n_r && !$past(strobe_n_r)) ? CNT_W'(1) :
            (end_cnt_r == sat_max ? end_cnt_r : end_cnt_r + CNT_W'(1));
         gap_cnt_r <= (!sel_n_r && $past(sel_n_r)) ? CNT_W'(1) :
            (gap_cnt_r == sat_max ? gap_cnt_r : gap_cnt_r + CNT_W'(1));
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_READ_STROBE_HIGH: assert property (!output_gate_n_o |-> write_strobe_n_o)
      else $error("strobe low during read");
   AST_PULSE_WIDTH: assert property ($rose(write_strobe_n_o) |-> low_cnt_r >= WP_CYC)
      else $error("write pulse too short");
   AST_SELECT_LEAD: assert property ($rose(write_strobe_n_o) |-> sel_cnt_r >= CW_CYC)
      else $error("selects not active long enough before write end");
   AST_ADDR_STABLE: assert property (!write_strobe_n_o |-> $stable(ram_addr_o) && sel_cnt_r >= 1)
      else $error("address moved during write");
   AST_DATA_OVERLAP: assert property ($rose(write_strobe_n_o) |-> $past(doe_cnt_r) >= DW_CYC)
      else $error("write data window too short");
   AST_DATA_OFF_AT_END: assert property ($rose(write_strobe_n_o) |-> !data_oe_o)
      else $error("drivers still on after write end");
   AST_RECOVERY: assert property ($changed(ram_addr_o) |-> end_cnt_r > WR1_CYC)
      else $error("address changed inside write recovery");
   AST_NO_FIGHT: assert property (data_oe_o |-> output_gate_n_o && !write_strobe_n_o && sel_cnt_r >= 2)
      else $error("drivers on outside the strobe window");
   AST_SPACING: assert property ($fell(select_low_active_n_o) |-> $past(gap_cnt_r) >= RC_CYC)
      else $error("accesses closer than one cycle time");
   COV_WRITE: cover property ($rose(write_strobe_n_o) ##[1:40] ready_o);
   COV_READ: cover property ($fell(output_gate_n_o) ##[1:40] rvalid_o);
   COV_WRITE_THEN_READ: cover property ($rose(write_strobe_n_o) ##[1:60] $fell(output_gate_n_o));
endmodule // sap_host
`default_nettype wire

// ===== verif/sap_ram_model.sv
// Behavioural model of the 8K x 8 static RAM on the far side of the host
`default_nettype none
module sap_ram_model import sap_pkg::*;
(
   input wire logic clk_i,
   input wire logic [3:0] lat_i, // Gate to valid data, in cycles, less one
   input wire logic [ADDR_W-1:0] addr_i, // Address pins
   input wire logic sel_n_i, // Low active select
   input wire logic sel_i, // High active select
   input wire logic we_n_i, // Write strobe
   input wire logic oe_n_i, // Output gate
   input wire logic [DATA_W-1:0] bus_i, // Resolved data pins
   output logic [DATA_W-1:0] q_o, // Byte the RAM puts out
   output logic drive_o // RAM drives the pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Storage array
   logic [3:0] cnt_r = 4'h0; // Cycles since the read path opened
   logic wr_r = 1'b0; // Write was active last cycle
   logic [ADDR_W-1:0] wa_r; // Address seen during the write
   logic [DATA_W-1:0] wd_r; // Data seen during the write
   wire logic sel = !sel_n_i && sel_i; // Either select off deselects
   wire logic wr = sel && !we_n_i; // Write needs all three
   wire logic rd = sel && we_n_i && !oe_n_i; // Read path, strobe must be high
   // Zero hold: commit what the pins carried just before the first releasing edge
   always @(posedge clk_i) begin
      wr_r <= wr;
      wa_r <= addr_i;
      wd_r <= bus_i;
      if (wr_r && !wr) mem[wa_r] <= wd_r;
      if (!rd) cnt_r <= 4'h0; // Release after deselect or strobe
      else if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1; // Drives a cycle late
   end
   assign drive_o = (cnt_r != 4'h0); // Three-state output
   // Junk that changes each cycle until the access has settled
   assign q_o = (cnt_r > lat_i) ? mem[addr_i] : ~mem[addr_i] ^ {4'h0, cnt_r};
endmodule // sap_ram_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the static RAM host controller
`default_nettype none
module testbench import sap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, we_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0, ram_addr_o, pa;
   logic [DATA_W-1:0] wdata_i = '0, data_i, last_r = '0, rdata_o, data_o, q;
   logic ready_o, rvalid_o, select_low_active_n_o, select_high_active_o, write_strobe_n_o;
   logic output_gate_n_o, data_oe_o, drive, pw = 1'b1;
   logic [3:0] lat = 4'h1; // Prompt RAM by default
   int fail_count = 0, n_compared = 0, cyc = 0, wl = 0, sl = 0, dl = 0, al = 0, since = 99;
   always #2.5 clk_i = ~clk_i;
   // Resolved pins; a released bus shows the inverse of its last value
   assign data_i = data_oe_o ? data_o : (drive ? q : ~last_r);
   always @(posedge clk_i) last_r <= data_i;
   sap_host u_sap_host (.clk_i, .rst_i, .req_i, .we_i, .addr_i, .wdata_i, .ready_o, .rvalid_o, .rdata_o,
      .ram_addr_o, .select_low_active_n_o, .select_high_active_o, .write_strobe_n_o, .output_gate_n_o,
      .data_i, .data_o, .data_oe_o);
   sap_ram_model u_sap_ram_model (.clk_i, .lat_i(lat), .addr_i(ram_addr_o), .sel_n_i(select_low_active_n_o),
      .sel_i(select_high_active_o), .we_n_i(write_strobe_n_o), .oe_n_i(output_gate_n_o), .bus_i(data_i),
      .q_o(q), .drive_o(drive));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   // Pin watch at the falling edge, where every output has settled
   always @(negedge clk_i) begin
      if (!rst_i) begin
         if (!write_strobe_n_o) begin
            check({select_low_active_n_o, select_high_active_o, output_gate_n_o}, 3'b011);
         end
         if (drive) check(data_oe_o, 1'b0);
         if (data_oe_o) check(write_strobe_n_o, 1'b0);
         if (write_strobe_n_o && !pw) begin
            check(wl >= WP_CYC, 1'b1);
            check(sl >= CW_CYC, 1'b1);
            check(al >= AW_CYC, 1'b1);
            check(dl >= DW_CYC, 1'b1);
         end
         if (ram_addr_o !== pa) check(since >= WR1_CYC, 1'b1);
         // The cycle in which the address changed already counts as stable
         al = (ram_addr_o === pa) ? al + 1 : 1;
         wl = write_strobe_n_o ? 0 : wl + 1;
         sl = (!select_low_active_n_o && select_high_active_o) ? sl + 1 : 0;
         dl = data_oe_o ? dl + 1 : 0;
         since = (write_strobe_n_o && !pw) ? 0 : since + 1;
      end
      pa = ram_addr_o;
      pw = write_strobe_n_o;
   end
   // One access through the user port; a read waits for its byte
   task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] r);
      int n;
      n = 0;
      // Let ready from a take in this time step settle before looking at it
      @(negedge clk_i);
      while (ready_o !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      @(posedge clk_i);
      req_i <= 1'b1;
      we_i <= w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      req_i <= 1'b0;
      r = 'x;
      if (!w) begin
         n = 0;
         while (rvalid_o !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
         end
         check(n >= 28 && n < 40, 1'b1);
         r = rdata_o;
      end
   endtask
   // Idle pins right after reset
   task automatic t_reset;
      @(negedge clk_i);
      check({select_low_active_n_o, select_high_active_o, write_strobe_n_o}, 3'b101);
      check({output_gate_n_o, data_oe_o}, 2'b10);
   endtask
   // Both ends of the array, back to back, one overwrite
   task automatic t_boundary;
      logic [ADDR_W-1:0] a [3] = '{13'h0000, 13'h1fff, 13'h0aaa};
      logic [DATA_W-1:0] r;
      foreach (a[i]) op(1'b1, a[i], 8'h3c ^ 8'(i), r);
      op(1'b1, 13'h0aaa, 8'hc5, r);
      foreach (a[i]) begin
         op(1'b0, a[i], 8'h00, r);
         check(r, (i == 2) ? 8'hc5 : 8'h3c ^ 8'(i));
      end
   endtask
   // A request while busy leaves no trace
   task automatic t_refused;
      logic [DATA_W-1:0] r;
      op(1'b1, 13'h0005, 8'h5a, r);
      @(posedge clk_i);
      req_i <= 1'b1;
      wdata_i <= 8'ha5;
      @(posedge clk_i);
      req_i <= 1'b0;
      op(1'b0, 13'h0005, 8'h00, r);
      check(r, 8'h5a);
   endtask
   // Slowest legal gate-to-data figure still reads right
   task automatic t_slow;
      logic [DATA_W-1:0] r;
      lat <= 4'hb; // Data valid exactly 60 ns after the gate falls
      op(1'b0, 13'h1fff, 8'h00, r);
      check(r, 8'h3d);
      lat <= 4'h1;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_boundary();
      t_refused();
      t_slow();
      finish_test();
   end
endmodule // testbench
`default_nettype wire
